// File: dcec_top.sv
// Top: Avalon-MM control register and registered DAC enable outputs
// Function
// RULE1 - Both output enables low: no conversion
// RULE2 - Only channel 0 enabled: channel 0 converts
// RULE3 - Only channel 1 enabled: channel 1 converts
// RULE4 - One enable plus shared bit: both convert
// RULE5 - Both output enables high: both convert
// RULE6 - Channel 1 pin driven only while enabled
// RULE7 - Reset clears all three enable bits
`timescale 1ns/10ps
module dcec_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic chan0_convert,
    output logic chan1_convert,
    output logic chan0_analog_out_en,
    output logic chan1_analog_out
);
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    dcec_pkg::dcec_ctrl_s ctrl;
    dcec_pkg::dcec_enables_s enables;
    logic req;

    assign req = avs_read | avs_write;
    assign ctrl.chan1_output_enable = control_reg[dcec_pkg::BIT_CH1_OE];
    assign ctrl.chan0_output_enable = control_reg[dcec_pkg::BIT_CH0_OE];
    assign ctrl.shared_conversion_enable =
        control_reg[dcec_pkg::BIT_SHARED_EN];

    // One wait state: answer lands one cycle after request is seen
    always_comb begin
        control_next = control_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        if (req && !ack_reg) begin
            ack_next = 1'b1;
            if (avs_write && avs_address == dcec_pkg::ADDR_CONTROL &&
                avs_byteenable[0]) begin
                control_next = avs_writedata[7:0] & ~dcec_pkg::RESERVED_MASK;
            end
            if (avs_read) begin
                unique case (avs_address)
                    dcec_pkg::ADDR_CONTROL: begin
                        rdata_next = {24'h00_0000,
                            control_reg | dcec_pkg::RESERVED_READ};
                    end
                    dcec_pkg::ADDR_STATUS: begin
                        rdata_next = {28'h000_0000, enables};
                    end
                    default: begin
                        rdata_next = dcec_pkg::UNMAPPED_READ;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            control_reg <= dcec_pkg::CONTROL_RESET; // RULE7
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
        end else begin
            control_reg <= control_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    dcec_decode u_decode (
        .clock(clock),
        .rst_n(rst_n),
        .ctrl(ctrl),
        .enables(enables)
    );

    // Waitrequest high by default so a fresh request always stalls once
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req && !ack_reg);
        end
    end

    assign avs_readdata = rdata_reg;
    assign chan0_convert = enables.chan0_convert;
    assign chan1_convert = enables.chan1_convert;
    assign chan0_analog_out_en = enables.chan0_drive;
    assign chan1_analog_out = enables.chan1_drive; // RULE6
endmodule : dcec_top

// File: dcec_pkg.sv
// Package: register map, field positions and carrier types for DAC enable
package dcec_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int BIT_CH1_OE = 7;
    localparam int BIT_CH0_OE = 6;
    localparam int BIT_SHARED_EN = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RESERVED_MASK = 8'h1f;
    localparam logic [7:0] RESERVED_READ = 8'h1f;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef struct packed {
        logic chan1_output_enable;
        logic chan0_output_enable;
        logic shared_conversion_enable;
    } dcec_ctrl_s;

    typedef struct packed {
        logic chan1_convert;
        logic chan0_convert;
        logic chan1_drive;
        logic chan0_drive;
    } dcec_enables_s;
endpackage : dcec_pkg

// File: dcec_decode.sv
// Decode of the three enable bits into conversion and drive enables
`timescale 1ns/10ps
module dcec_decode (
    input wire logic clock,
    input wire logic rst_n,
    input wire dcec_pkg::dcec_ctrl_s ctrl,
    output dcec_pkg::dcec_enables_s enables
);
    dcec_pkg::dcec_enables_s enables_reg;
    dcec_pkg::dcec_enables_s enables_next;
    logic oe1;
    logic oe0;
    logic shr;

    always_comb begin
        oe1 = ctrl.chan1_output_enable;
        oe0 = ctrl.chan0_output_enable;
        shr = ctrl.shared_conversion_enable;
        enables_next = '0;
        unique case ({oe1, oe0})
            2'b00: begin
                enables_next.chan0_convert = 1'b0; // RULE1
                enables_next.chan1_convert = 1'b0; // RULE1
            end
            2'b01: begin
                enables_next.chan0_convert = 1'b1; // RULE2
                enables_next.chan1_convert = shr; // RULE2 RULE4
            end
            2'b10: begin
                enables_next.chan0_convert = shr; // RULE3 RULE4
                enables_next.chan1_convert = 1'b1; // RULE3
            end
            2'b11: begin
                enables_next.chan0_convert = 1'b1; // RULE5
                enables_next.chan1_convert = 1'b1; // RULE5
            end
        endcase
        enables_next.chan1_drive = oe1; // RULE6
        enables_next.chan0_drive = oe0;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enables_reg <= '0; // RULE7
        end else begin
            enables_reg <= enables_next;
        end
    end

    assign enables = enables_reg;
endmodule : dcec_decode

// File: dcec_chk.sv
// Checks on the DAC enable outputs and on the bus wait state
`timescale 1ns/10ps
module dcec_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic chan0_convert,
    input wire logic chan1_convert,
    input wire logic chan1_analog_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [2:0] v = avs_writedata[7:5];
    wire c0 = chan0_convert;
    wire c1 = chan1_convert;
    sequence s_wr;
        avs_write && !avs_waitrequest && avs_byteenable[0] &&
        avs_address == dcec_pkg::ADDR_CONTROL;
    endsequence
    chk_none_off: assert property (s_wr ##0 v[2:1] == 0 |=> !c0 && !c1)
        else $error("conv on");
    chk_ch0_only: assert property (s_wr ##0 v == 3'b010 |=> c0 && !c1)
        else $error("ch0 only");
    chk_ch1_only: assert property (s_wr ##0 v == 3'b100 |=> !c0 && c1)
        else $error("ch1 only");
    chk_one_shared: assert property (s_wr ##0 ^v[2:1] && v[0] |=> c0 && c1)
        else $error("shared");
    chk_both_on: assert property (s_wr ##0 &v[2:1] |=> c0 && c1)
        else $error("both");
    chk_pin_follow: assert property (s_wr |=> chan1_analog_out == $past(v[2]))
        else $error("pin");
    chk_reset_clear: assert property ($rose(rst_n) |-> !c0 && !c1)
        else $error("reset");
    chk_wait_one: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait");
endmodule : dcec_chk
bind dcec_top dcec_chk u_chk (.*);

// File: dcec_far.sv
// Far-side model of the two analog output stages
`timescale 1ns/10ps
module dcec_far (
    input wire logic clock,
    input wire logic [1:0] drive,
    output logic [1:0] level
);
    logic [1:0] tog = 2'b01;
    // Undriven pins toggle so a stale level is never read as output
    always @(posedge clock) tog <= ~tog;
    assign level = drive | tog;
endmodule : dcec_far

// File: dac_channel_enable_control_test.sv
// Self-checking bench for the DAC enable control
`timescale 1ns/10ps
module dac_channel_enable_control_test;
    logic clock = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 0, avs_byteenable = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rdata;
    logic avs_waitrequest, chan0_convert, chan1_convert;
    logic chan0_analog_out_en, chan1_analog_out;
    logic [7:0] d;
    integer seed = 32'hd766_466c, n_fail = 0, n_tests = 0, cyc = 0, i;
    wire [31:0] pins = {28'h0, chan1_convert, chan0_convert,
        chan1_analog_out, chan0_analog_out_en};
    always #25 clock = ~clock;
    dcec_top dut (.*);
    dcec_far far (.clock, .drive(pins[1:0]), .level());
    function automatic logic [31:0] exp_stat(input logic [7:0] c);
        return {28'h0, c[7] | c[6] & c[5], c[6] | c[7] & c[5], c[7:6]};
    endfunction : exp_stat
    task automatic cmp(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] x, input logic [3:0] be);
        int n = 0;
        @(posedge clock);
        {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable}
            <= {w, !w, a, x, be};
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdata = avs_readdata;
        if (avs_waitrequest !== 1'b0) n_fail++;
        {avs_write, avs_read} <= 2'b00;
    endtask : bus
    task automatic print_verdict;
        $display("%0d checks, %0d bad", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        bus(0, 4'h0, 0, 4'hf);
        cmp("ctrl", {24'h0, dcec_pkg::RESERVED_READ}, rdata);
        cmp("pins", 0, pins);
        $display("reset done");
        for (i = 0; i < 24; i++) begin
            d = i < 8 ? 8'(i << 5) : 8'($random(seed));
            bus(1, 4'h0, {24'($random(seed)), d}, 4'h1);
            bus(0, 4'h4, 0, 4'hf);
            cmp("stat", exp_stat(d), rdata);
            cmp("pins", exp_stat(d), pins);
            bus(0, 4'h0, 0, 4'hf);
            cmp("ctrl", {24'h0, d & 8'he0 | 8'h1f}, rdata);
        end
        $display("decode done");
        bus(1, 4'h0, 32'h0, 4'he);
        bus(1, 4'h8, 32'h0, 4'hf);
        bus(0, 4'h8, 0, 4'hf);
        cmp("unmapped", 0, rdata);
        cmp("held", exp_stat(d), pins);
        $display("refuse done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        bus(0, 4'h0, 0, 4'hf);
        cmp("ctrl", {24'h0, dcec_pkg::RESERVED_READ}, rdata);
        cmp("pins", 0, pins);
        $display("mid reset done");
        print_verdict;
    end
endmodule : dac_channel_enable_control_test
